// File: qed_enc_model.sv
`timescale 1ns/100ps
// Stand-in encoder: quadrature tracks, index pulse and fault line
module qed_enc_model (
  input wire logic clk_i,
  output logic track_a_o,
  output logic track_b_o,
  output logic index_o,
  output logic fault_o
);
  logic [1:0] ph;

  // Encoder powers up at rest in phase 0
  initial begin
    ph = 2'h0;
    track_a_o = 1'b0;
    track_b_o = 1'b0;
    index_o = 1'b0;
    fault_o = 1'b0;
  end

  // One quarter period; spacing leaves the sync stage time to settle
  task automatic step(input logic up);
    repeat (4) @(posedge clk_i);
    ph = up ? ph + 2'h1 : ph - 2'h1;
    track_a_o <= ph[0] ^ ph[1];
    track_b_o <= ph[1];
  endtask

  // Deliberately broken step: both tracks flip at once
  task automatic both();
    repeat (4) @(posedge clk_i);
    ph = ph + 2'h2;
    track_a_o <= ph[0] ^ ph[1];
    track_b_o <= ph[1];
  endtask

  // Index pulse a few cycles wide
  task automatic pulse();
    repeat (4) @(posedge clk_i);
    index_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    index_o <= 1'b0;
  endtask

  // Fault line level change
  task automatic set_fault(input logic v);
    @(posedge clk_i);
    fault_o <= v;
  endtask
endmodule

// File: qed_pkg.sv
package qed_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] LINES_OFS = 8'h04;
  localparam logic [7:0] GEAR_OFS = 8'h08;
  localparam logic [7:0] POS_OFS = 8'h0C;
  localparam logic [7:0] ANGLE_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [7:0] CLR_OFS = 8'h18;
  localparam logic [7:0] IEN_OFS = 8'h1C;
  localparam logic [7:0] ERR_OFS = 8'h20;
  localparam logic [7:0] IDENT_OFS = 8'h24;
  // Control field positions
  localparam int ACT_BIT = 0;
  localparam int DIR_BIT = 1;
  localparam int IDX_BIT = 2;
  localparam int FEN_BIT = 3;
  localparam int FHI_BIT = 4;
  localparam int RST_BIT = 7;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h05;
  localparam logic [15:0] LINES_RST = 16'h0400;
  localparam logic [7:0] GEAR_NUM_RST = 8'h01;
  localparam logic [7:0] GEAR_DEN_RST = 8'h01;
  // Status bits
  localparam int ST_IDX = 0;
  localparam int ST_FLT = 1;
  localparam int ST_ILL = 2;
  localparam int ST_IDN = 3;
  localparam int ST_W = 4;
  // Encoder error codes, 08-4 and 08-2
  localparam logic [7:0] ERR_SQUARE = 8'h84;
  localparam logic [7:0] ERR_SINE = 8'h82;
  typedef enum {STEP_NONE, STEP_UP, STEP_DOWN, STEP_BAD} qed_step_type;
  typedef enum {ID_IDLE, ID_WAIT, ID_MEAS, ID_DONE} qed_id_type;
endpackage

// File: qed_sync.sv
`timescale 1ns/100ps
module qed_sync #(
  parameter int W = 4
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // Two stages; first stage feeds only the second
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// File: qed_top.sv
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// [R01] The encoder drives tracks A and B a quarter period apart.
// [R02] Every rising and falling edge of both tracks is one count.
// [R03] One revolution spans four counts per configured line.
// [R04] With line count zero and index on, a run measures it.
// [R05] The fault input has its own enable and active level.
// [R06] An active enabled fault input raises error code 08-4.
// [R07] A gear ratio scales counts to motor position, default 1:1.
// [R08] When inactive, no position, angle or valid is produced.
// [R09] A direction bit sets the count sense; the run learns it.
// [R10] Configuration waits until a restart before it applies.
// [R11] With index on, each index pulse zeroes the angle.
// [R12] Inputs are synchronised; a double change is a fault.
module qed_top (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic track_a_i,
  input wire logic track_b_i,
  input wire logic index_i,
  input wire logic encoder_fault_i,
  output logic irq_o,
  output logic [31:0] pos_o,
  output logic pos_valid_o
);
  logic [3:0] sync_w;
  logic a_s, b_s, idx_s, flt_s;
  logic [1:0] ab_prev_r;
  logic idx_prev_r;
  logic idx_rise;
  qed_pkg::qed_step_type step;
  // Pending and applied configuration
  logic [7:0] ctrl_r;
  logic [15:0] lines_r;
  logic [7:0] num_r, den_r;
  logic act_a, dir_a, idx_a, fen_a, fhi_a;
  logic [15:0] lines_a;
  logic [7:0] num_a, den_a;
  logic restart;
  // Counters
  logic [17:0] angle_r, cpr;
  logic [8:0] res_r, res_sum;
  logic [31:0] pos_r;
  logic signed [19:0] meas_r;
  qed_pkg::qed_id_type id_r;
  // Events and interrupts
  logic [qed_pkg::ST_W-1:0] stat_r, ien_r, ev, clr;
  logic flt_lvl;
  logic [7:0] err_r;
  logic wb_req, wb_wr;

  // Quadrature step decode from old and new track pair
  function automatic qed_pkg::qed_step_type dec(input logic [1:0] p,
                                                input logic [1:0] c);
    logic [1:0] x;
    x = p ^ c;
    if (x == 2'h0)
      return qed_pkg::STEP_NONE;
    else if (x == 2'h3)
      return qed_pkg::STEP_BAD; // [R12]
    else if ((p[1] ^ c[0]) == 1'b0)
      return qed_pkg::STEP_UP;
    else
      return qed_pkg::STEP_DOWN;
  endfunction

  qed_sync #(.W(4)) u_sync (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .d_i({track_a_i, track_b_i, index_i, encoder_fault_i}),
    .q_o(sync_w)
  ); // [R12]
  assign {a_s, b_s, idx_s, flt_s} = sync_w;

  // Previous samples for edge and step detection
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ab_prev_r <= 2'h0;
      idx_prev_r <= 1'b0;
    end else begin
      ab_prev_r <= {a_s, b_s};
      idx_prev_r <= idx_s;
    end
  end

  // Tracks 90 degrees apart give single-bit changes only [R01]
  assign step = dec(ab_prev_r, {a_s, b_s}); // [R02]
  assign idx_rise = idx_s & ~idx_prev_r;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_req & wb_we_i;
  assign restart = wb_wr && wb_adr_i == qed_pkg::CTRL_OFS &&
                   wb_sel_i[0] && wb_dat_i[qed_pkg::RST_BIT];

  // Pending configuration; software writes land here first
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= qed_pkg::CTRL_RST;
      lines_r <= qed_pkg::LINES_RST;
      num_r <= qed_pkg::GEAR_NUM_RST;
      den_r <= qed_pkg::GEAR_DEN_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        qed_pkg::CTRL_OFS: begin
          if (wb_sel_i[0])
            ctrl_r <= {1'b0, wb_dat_i[6:0]};
        end
        qed_pkg::LINES_OFS: begin
          if (wb_sel_i[0])
            lines_r[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            lines_r[15:8] <= wb_dat_i[15:8];
        end
        qed_pkg::GEAR_OFS: begin
          if (wb_sel_i[0])
            num_r <= wb_dat_i[7:0];
          if (wb_sel_i[1])
            den_r <= wb_dat_i[15:8];
        end
        default: ;
      endcase
    end
  end

  // Applied configuration changes at reset or restart, and at the end of an identification run [R10]
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      act_a <= qed_pkg::CTRL_RST[qed_pkg::ACT_BIT];
      dir_a <= qed_pkg::CTRL_RST[qed_pkg::DIR_BIT];
      idx_a <= qed_pkg::CTRL_RST[qed_pkg::IDX_BIT];
      fen_a <= qed_pkg::CTRL_RST[qed_pkg::FEN_BIT];
      fhi_a <= qed_pkg::CTRL_RST[qed_pkg::FHI_BIT];
      lines_a <= qed_pkg::LINES_RST;
      num_a <= qed_pkg::GEAR_NUM_RST;
      den_a <= qed_pkg::GEAR_DEN_RST;
    end else if (restart) begin
      act_a <= ctrl_r[qed_pkg::ACT_BIT]; // [R10]
      dir_a <= ctrl_r[qed_pkg::DIR_BIT];
      idx_a <= ctrl_r[qed_pkg::IDX_BIT];
      fen_a <= ctrl_r[qed_pkg::FEN_BIT];
      fhi_a <= ctrl_r[qed_pkg::FHI_BIT];
      lines_a <= lines_r;
      num_a <= num_r;
      den_a <= den_r;
    end else if (id_r == qed_pkg::ID_MEAS && idx_rise) begin
      // Run stores periods per index and the count sense
      lines_a <= meas_r[19] ? 16'((-meas_r) >>> 2)
                            : 16'(meas_r >>> 2); // [R04]
      dir_a <= meas_r[19]; // [R09]
    end
  end

  // Identification run; starts after a restart that applies line count zero with index on
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      id_r <= qed_pkg::ID_IDLE;
      meas_r <= '0;
    end else if (restart) begin
      id_r <= qed_pkg::ID_IDLE;
      meas_r <= '0;
    end else begin
      case (id_r)
        qed_pkg::ID_IDLE: begin
          if (act_a && idx_a && lines_a == 16'h0000)
            id_r <= qed_pkg::ID_WAIT; // [R04]
        end
        qed_pkg::ID_WAIT: begin
          meas_r <= '0;
          if (idx_rise)
            id_r <= qed_pkg::ID_MEAS;
        end
        qed_pkg::ID_MEAS: begin
          // Raw count, before the direction bit
          if (idx_rise)
            id_r <= qed_pkg::ID_DONE;
          else if (step == qed_pkg::STEP_UP)
            meas_r <= meas_r + 20'sh00001;
          else if (step == qed_pkg::STEP_DOWN)
            meas_r <= meas_r - 20'sh00001;
        end
        qed_pkg::ID_DONE: ;
        default: id_r <= qed_pkg::ID_IDLE;
      endcase
    end
  end

  // Four counts per line make one revolution [R03]
  assign cpr = {lines_a, 2'b00};
  assign res_sum = res_r + {1'b0, num_a};

  // Angle within a revolution and geared motor position
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      angle_r <= '0;
      pos_r <= '0;
      res_r <= '0;
    end else if (restart || !act_a) begin
      angle_r <= '0; // [R08]
      pos_r <= '0;
      res_r <= '0;
    end else if (idx_a && idx_rise) begin
      angle_r <= '0; // [R11]
    end else if (step == qed_pkg::STEP_UP ||
                 step == qed_pkg::STEP_DOWN) begin
      if ((step == qed_pkg::STEP_UP) != dir_a) begin // [R09]
        if (lines_a != 16'h0000 && angle_r == cpr - 18'h00001)
          angle_r <= '0; // [R03]
        else
          angle_r <= angle_r + 18'h00001; // [R02]
      end else begin
        if (lines_a != 16'h0000 && angle_r == 18'h00000)
          angle_r <= cpr - 18'h00001;
        else
          angle_r <= angle_r - 18'h00001;
      end
      // Fractional gear, one motor step at most per count
      if (res_sum >= {1'b0, den_a}) begin
        res_r <= res_sum - {1'b0, den_a}; // [R07]
        if ((step == qed_pkg::STEP_UP) != dir_a)
          pos_r <= pos_r + 32'h00000001;
        else
          pos_r <= pos_r - 32'h00000001;
      end else begin
        res_r <= res_sum;
      end
    end
  end

  // Fault level, enable and polarity applied [R05]
  assign flt_lvl = act_a & fen_a & (flt_s == fhi_a);

  // Error code register holds the last raised code
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      err_r <= 8'h00;
    else if (flt_lvl)
      err_r <= qed_pkg::ERR_SQUARE; // [R06]
  end

  // Event sources for the sticky status bits
  always_comb begin
    ev = '0;
    ev[qed_pkg::ST_IDX] = act_a & idx_a & idx_rise;
    ev[qed_pkg::ST_FLT] = flt_lvl; // [R06]
    ev[qed_pkg::ST_ILL] = act_a & (step == qed_pkg::STEP_BAD); // [R12]
    ev[qed_pkg::ST_IDN] = (id_r == qed_pkg::ID_MEAS) & idx_rise;
  end
  assign clr = (wb_wr && wb_adr_i == qed_pkg::CLR_OFS && wb_sel_i[0]) ?
               wb_dat_i[qed_pkg::ST_W-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      stat_r <= '0;
    else
      stat_r <= (stat_r & ~clr) | ev;
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i)
      ien_r <= '0;
    else if (wb_wr && wb_adr_i == qed_pkg::IEN_OFS && wb_sel_i[0])
      ien_r <= wb_dat_i[qed_pkg::ST_W-1:0];
  end

  // Registered outputs; valid only while active [R08]
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
      pos_o <= '0;
      pos_valid_o <= 1'b0;
    end else begin
      irq_o <= |(stat_r & ien_r);
      pos_o <= pos_r;
      pos_valid_o <= act_a;
    end
  end

  // Bus slave: ack one cycle after the request, one cycle long
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0; // Unmapped reads return zero
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          qed_pkg::CTRL_OFS: wb_dat_o <= {24'h000000, ctrl_r};
          qed_pkg::LINES_OFS: wb_dat_o <= {16'h0000, lines_r};
          qed_pkg::GEAR_OFS: wb_dat_o <= {16'h0000, den_r, num_r};
          qed_pkg::POS_OFS: wb_dat_o <= pos_r;
          qed_pkg::ANGLE_OFS: wb_dat_o <= {14'h0000, angle_r};
          qed_pkg::STAT_OFS: wb_dat_o <= 32'(stat_r);
          qed_pkg::IEN_OFS: wb_dat_o <= 32'(ien_r);
          qed_pkg::ERR_OFS: wb_dat_o <= {24'h000000, err_r};
          qed_pkg::IDENT_OFS: wb_dat_o <= {15'h0000, dir_a, lines_a};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_timing_a: assert property (wb_req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  quad_up_a: assert property ( // [R02]
    act_a && !restart && !(idx_a && idx_rise) && !dir_a &&
    step == qed_pkg::STEP_UP && lines_a != 16'h0000 &&
    angle_r != cpr - 18'h00001 |=> angle_r == $past(angle_r) + 18'h1)
    else $error("up step did not advance angle");
  rev_wrap_a: assert property ( // [R03]
    lines_a != 16'h0000 |-> angle_r < cpr)
    else $error("angle beyond one revolution");
  fault_raise_a: assert property (flt_lvl |=> stat_r[qed_pkg::ST_FLT] &&
    err_r == qed_pkg::ERR_SQUARE) // [R06]
    else $error("enabled fault did not raise 08-4");
  fault_gate_a: assert property (!fen_a |-> !ev[qed_pkg::ST_FLT])
    else $error("disabled fault input raised"); // [R05]
  inactive_a: assert property (!act_a |=> !pos_valid_o ##1 pos_o == 0)
    else $error("inactive decoder gave output"); // [R08]
  restart_apply_a: assert property (restart |=>
    act_a == $past(ctrl_r[qed_pkg::ACT_BIT]) &&
    lines_a == $past(lines_r)) // [R10]
    else $error("restart did not apply pending config");
  index_zero_a: assert property (act_a && idx_a && idx_rise && !restart
    |=> angle_r == 18'h00000) // [R11]
    else $error("index did not zero angle");
  bad_step_a: assert property (act_a && step == qed_pkg::STEP_BAD
    |=> stat_r[qed_pkg::ST_ILL]) // [R12]
    else $error("double change not flagged");
  ident_store_a: assert property (id_r == qed_pkg::ID_MEAS && idx_rise &&
    !restart && !meas_r[19] |=> lines_a == 16'($past(meas_r) >>> 2) &&
    !dir_a) // [R04]
    else $error("identification stored wrong line count");
  irq_level_a: assert property (1 |=> irq_o == |$past(stat_r & ien_r))
    else $error("irq not tracking enabled status");

  ident_done_c: cover property (id_r == qed_pkg::ID_DONE);
  index_hit_c: cover property (ev[qed_pkg::ST_IDX]);
  fault_hit_c: cover property (ev[qed_pkg::ST_FLT] ##1 irq_o);
  restart_c: cover property (restart);
endmodule

// File: tb.sv
`timescale 1ns/100ps
module tb;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] pos_o;
  logic [31:0] rdat;
  logic wb_ack_o, irq_o, pos_valid_o, trk_a, trk_b, idx, flt;
  int bad_count = 0;
  int checks = 0;

  // 100 MHz clock
  always #5 sys_clk_i = ~sys_clk_i;

  qed_top qed_top_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .track_a_i(trk_a),
    .track_b_i(trk_b), .index_i(idx), .encoder_fault_i(flt),
    .irq_o(irq_o), .pos_o(pos_o), .pos_valid_o(pos_valid_o));

  qed_enc_model qed_enc_model_inst (.clk_i(sys_clk_i), .track_a_o(trk_a),
    .track_b_o(trk_b), .index_o(idx), .fault_o(flt));

  task stop_test;
    $display("Checks %0d, errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic cycle; held until ack is sampled high, released at that edge
  task bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      $display("Error at %0t: no bus ack", $time);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // Fixed wait covers the sync chain plus position register lag
  task settle;
    repeat (6) @(posedge sys_clk_i);
  endtask

  task steps(input logic up, input int n);
    repeat (n) qed_enc_model_inst.step(up);
    settle;
  endtask

  // Restart applies what was pending before it, so stage c first
  task restart(input logic [7:0] c);
    wr(qed_pkg::CTRL_OFS, {24'h0, c});
    wr(qed_pkg::CTRL_OFS, {24'h0, c | 8'h80});
    settle;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    stop_test;
  end

  initial begin
    repeat (3) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    rc(qed_pkg::CTRL_OFS, 32'h5);
    rc(qed_pkg::LINES_OFS, 32'h400);
    rc(qed_pkg::GEAR_OFS, 32'h101);
    rc(qed_pkg::IDENT_OFS, 32'h400);
    rc(8'h3C, 32'h0);
    rc(qed_pkg::ERR_OFS, 32'h0);
    steps(1'b1, 4);
    rc(qed_pkg::ANGLE_OFS, 32'h4);
    chk(pos_o, 32'h4);
    chk({31'h0, pos_valid_o}, 32'h1);
    // Direction change stays pending until restart
    wr(qed_pkg::CTRL_OFS, 32'h7);
    steps(1'b1, 2);
    rc(qed_pkg::ANGLE_OFS, 32'h6);
    rc(qed_pkg::IDENT_OFS, 32'h400);
    restart(8'h07);
    rc(qed_pkg::IDENT_OFS, 32'h10400);
    steps(1'b1, 2);
    rc(qed_pkg::ANGLE_OFS, 32'hFFE);
    rc(qed_pkg::POS_OFS, 32'hFFFFFFFE);
    // Index zeroes angle only when enabled
    restart(8'h05);
    steps(1'b1, 3);
    qed_enc_model_inst.pulse();
    settle;
    rc(qed_pkg::ANGLE_OFS, 32'h0);
    restart(8'h01);
    steps(1'b1, 3);
    qed_enc_model_inst.pulse();
    settle;
    rc(qed_pkg::ANGLE_OFS, 32'h3);
    // One line per revolution, gear 1:2
    wr(qed_pkg::LINES_OFS, 32'h1);
    wr(qed_pkg::GEAR_OFS, 32'h201);
    restart(8'h01);
    steps(1'b1, 4);
    rc(qed_pkg::ANGLE_OFS, 32'h0);
    rc(qed_pkg::POS_OFS, 32'h2);
    // Double change: sticky status, masked then enabled irq
    wr(qed_pkg::CLR_OFS, 32'hF);
    qed_enc_model_inst.both();
    settle;
    rc(qed_pkg::STAT_OFS, 32'h4);
    chk({31'h0, irq_o}, 32'h0);
    wr(qed_pkg::IEN_OFS, 32'h4);
    settle;
    chk({31'h0, irq_o}, 32'h1);
    wr(qed_pkg::CLR_OFS, 32'h4);
    settle;
    chk({31'h0, irq_o}, 32'h0);
    rc(qed_pkg::STAT_OFS, 32'h0);
    // Fault line, high-active then low-active then disabled
    restart(8'h19);
    qed_enc_model_inst.set_fault(1'b1);
    settle;
    rc(qed_pkg::STAT_OFS, 32'h2);
    rc(qed_pkg::ERR_OFS, {24'h0, qed_pkg::ERR_SQUARE});
    restart(8'h09);
    wr(qed_pkg::CLR_OFS, 32'hF);
    settle;
    rc(qed_pkg::STAT_OFS, 32'h0);
    qed_enc_model_inst.set_fault(1'b0);
    settle;
    rc(qed_pkg::STAT_OFS, 32'h2);
    restart(8'h01);
    wr(qed_pkg::CLR_OFS, 32'hF);
    settle;
    rc(qed_pkg::STAT_OFS, 32'h0);
    // Line count learnt between two index pulses
    wr(qed_pkg::LINES_OFS, 32'h0);
    restart(8'h05);
    qed_enc_model_inst.pulse();
    steps(1'b1, 8);
    qed_enc_model_inst.pulse();
    settle;
    rc(qed_pkg::IDENT_OFS, 32'h2);
    rc(qed_pkg::STAT_OFS, 32'h9);
    // Inactive decoder produces nothing
    restart(8'h00);
    chk({31'h0, pos_valid_o}, 32'h0);
    steps(1'b1, 2);
    rc(qed_pkg::ANGLE_OFS, 32'h0);
    chk(pos_o, 32'h0);
    stop_test;
  end
endmodule
